// file: core/vpcc_pkg.sv
// Package of register offsets, field positions and reset values for the channel control bank.
package vpcc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_CHAN_ZERO = 8'h00;
	localparam logic [7:0] OFF_CHAN_ONE = 8'h04;
	localparam logic [7:0] OFF_CHAN_TWO = 8'h08;
	localparam logic [7:0] OFF_RUN_STATUS = 8'h0C;
	// Channel 0 and channel 1 share one field layout in the low bits.
	localparam int POS_ENABLE = 0;
	localparam int POS_KIND_LO = 1;
	localparam int POS_KIND_HI = 2;
	localparam int POS_SHARED = 3;
	localparam int POS_LAYOUT = 4;
	localparam int POS_FIELD = 5;
	localparam int POS_EDGE = 31;
	localparam int POS_CLIP = 14;
	localparam int POS_RUN_ZERO = 0;
	localparam int POS_RUN_ONE = 1;
	localparam int POS_RUN_RAW = 2;
	localparam logic RST_ENABLE = 1'h0;
	localparam logic [1:0] RST_KIND = 2'h0;
	localparam logic RST_SHARED = 1'h0;
	localparam logic RST_LAYOUT = 1'h0;
	localparam logic RST_FIELD = 1'h0;
	localparam logic RST_EDGE = 1'h0;
	localparam logic RST_CLIP = 1'h0;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;
	localparam logic LAYOUT_RASTER = 1'h0;
	localparam logic LAYOUT_SUBPIC = 1'h1;
	localparam logic SHARED_FORCE = 1'h1;
endpackage

// file: core/vpcc_channel_control.sv
// Channel control register bank of the video port with run gating and field capture.
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: Channel one bit 4 picks luma memory layout: 0 raster, 1 sub-picture.
// R2: Layout selection only acts for embedded-sync video formats.
// R3: Ancillary data always uses raster order regardless of layout.
// R4: Channel one bit 3: 0 separate Y and C streams, 1 shared stream.
// R5: Separate streams need both channel enables before anything runs.
// R6: Separate streams force the channel zero shared-stream bit to one.
// R7: Shared-stream video lets each channel run on its own enable.
// R8: Capture kind bits 2 to 1, codes 0 and 1: embedded-sync video.
// R9: Capture kind codes 2 and 3: raw sensor capture, separate syncs.
// R10: Software programs channel zero and one capture kinds equal in raw mode.
// R11: Raw capture stays idle unless both channel enables are one.
// R12: Channel one bit 0 enables channel one.
// R13: Channel two bit 31 selects data change edge: 0 rising, 1 falling.
// R14: Edge selection only leaves as a register signal; handled outside.
// R15: Channel two bit 14 enables blanking region clipping.
// R16: With channel one enabled, each interrupt pulse latches the field identity.
// R17: Reserved channel two bits read zero and ignore writes.
module vpcc_channel_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic field_pulse,
	input wire logic field_identity,
	output logic chan_zero_enable,
	output logic chan_zero_luma_chroma_shared,
	output logic [1:0] chan_zero_capture_kind,
	output logic chan_one_enable,
	output logic chan_one_luma_chroma_shared,
	output logic [1:0] chan_one_capture_kind,
	output logic chan_one_memory_layout_sel,
	output logic chan_one_anc_layout_sel,
	output logic chan_one_field_flag,
	output logic chan_zero_run,
	output logic chan_one_run,
	output logic raw_capture_run,
	output logic chan_two_edge_select,
	output logic blanking_clip_enable
);

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic z_en;
		logic [1:0] z_kind;
		logic z_shared;
		logic o_en;
		logic [1:0] o_kind;
		logic o_shared;
		logic o_layout;
		logic o_field;
		logic t_edge;
		logic t_clip;
		logic luma_layout;
		logic z_run;
		logic o_run;
		logic raw_run;
		logic [31:0] rdata;
	} vpcc_state_t;

	vpcc_state_t state_reg;
	vpcc_state_t state_next;

	logic wr_zero;
	logic wr_one;
	logic wr_two;
	logic raw_mode;
	logic joint_mode;
	logic both_en;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		wr_zero = 1'h0;
		wr_one = 1'h0;
		wr_two = 1'h0;
		if (reg_write) begin
			if (reg_addr == vpcc_pkg::OFF_CHAN_ZERO) begin
				wr_zero = 1'h1;
			end else if (reg_addr == vpcc_pkg::OFF_CHAN_ONE) begin
				wr_one = 1'h1;
			end else if (reg_addr == vpcc_pkg::OFF_CHAN_TWO) begin
				wr_two = 1'h1;
			end
		end

		if (wr_zero) begin
			state_next.z_en = reg_wdata[vpcc_pkg::POS_ENABLE];
			state_next.z_kind = reg_wdata[vpcc_pkg::POS_KIND_HI:vpcc_pkg::POS_KIND_LO];
			state_next.z_shared = reg_wdata[vpcc_pkg::POS_SHARED];
		end
		if (wr_one) begin
			state_next.o_en = reg_wdata[vpcc_pkg::POS_ENABLE]; // R12
			state_next.o_kind = reg_wdata[vpcc_pkg::POS_KIND_HI:vpcc_pkg::POS_KIND_LO]; // R8
			state_next.o_shared = reg_wdata[vpcc_pkg::POS_SHARED]; // R4
			state_next.o_layout = reg_wdata[vpcc_pkg::POS_LAYOUT]; // R1
		end
		// Only bits 31 and 14 are stored; every other bit of the word is dropped.
		if (wr_two) begin
			state_next.t_edge = reg_wdata[vpcc_pkg::POS_EDGE]; // R13
			state_next.t_clip = reg_wdata[vpcc_pkg::POS_CLIP]; // R15
		end

		// Applied after the write so that a channel zero write cannot undo the force.
		if (!state_next.o_shared) begin
			state_next.z_shared = vpcc_pkg::SHARED_FORCE; // R6
		end

		// The field flag is a hardware status bit; software writes never touch it.
		if (state_reg.o_en && field_pulse) begin
			state_next.o_field = field_identity; // R16
		end

		raw_mode = state_next.o_kind[1]; // R9
		joint_mode = raw_mode || !state_next.o_shared;
		both_en = state_next.z_en && state_next.o_en;
		// Run gates are registered so the capture paths see glitch-free levels.
		if (joint_mode) begin
			state_next.z_run = both_en; // R5 R11
			state_next.o_run = both_en; // R5 R11
		end else begin
			state_next.z_run = state_next.z_en; // R7
			state_next.o_run = state_next.o_en; // R7
		end
		state_next.raw_run = raw_mode && both_en; // R11
		// Sub-picture layout is honoured only for embedded-sync video.
		state_next.luma_layout = raw_mode ? vpcc_pkg::LAYOUT_RASTER
			: state_next.o_layout; // R1 R2

		state_next.rdata = vpcc_pkg::RST_RDATA;
		if (reg_read) begin
			if (reg_addr == vpcc_pkg::OFF_CHAN_ZERO) begin
				state_next.rdata[vpcc_pkg::POS_ENABLE] = state_reg.z_en;
				state_next.rdata[vpcc_pkg::POS_KIND_HI:vpcc_pkg::POS_KIND_LO] = state_reg.z_kind;
				state_next.rdata[vpcc_pkg::POS_SHARED] = state_reg.z_shared;
			end else if (reg_addr == vpcc_pkg::OFF_CHAN_ONE) begin
				state_next.rdata[vpcc_pkg::POS_ENABLE] = state_reg.o_en;
				state_next.rdata[vpcc_pkg::POS_KIND_HI:vpcc_pkg::POS_KIND_LO] = state_reg.o_kind;
				state_next.rdata[vpcc_pkg::POS_SHARED] = state_reg.o_shared;
				state_next.rdata[vpcc_pkg::POS_LAYOUT] = state_reg.o_layout;
				state_next.rdata[vpcc_pkg::POS_FIELD] = state_reg.o_field;
			end else if (reg_addr == vpcc_pkg::OFF_CHAN_TWO) begin
				state_next.rdata[vpcc_pkg::POS_EDGE] = state_reg.t_edge;
				state_next.rdata[vpcc_pkg::POS_CLIP] = state_reg.t_clip; // R17
			end else if (reg_addr == vpcc_pkg::OFF_RUN_STATUS) begin
				state_next.rdata[vpcc_pkg::POS_RUN_ZERO] = state_reg.z_run;
				state_next.rdata[vpcc_pkg::POS_RUN_ONE] = state_reg.o_run;
				state_next.rdata[vpcc_pkg::POS_RUN_RAW] = state_reg.raw_run;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.z_en <= vpcc_pkg::RST_ENABLE;
			state_reg.z_kind <= vpcc_pkg::RST_KIND;
			state_reg.z_shared <= vpcc_pkg::SHARED_FORCE;
			state_reg.o_en <= vpcc_pkg::RST_ENABLE;
			state_reg.o_kind <= vpcc_pkg::RST_KIND;
			state_reg.o_shared <= vpcc_pkg::RST_SHARED;
			state_reg.o_layout <= vpcc_pkg::RST_LAYOUT;
			state_reg.o_field <= vpcc_pkg::RST_FIELD;
			state_reg.t_edge <= vpcc_pkg::RST_EDGE;
			state_reg.t_clip <= vpcc_pkg::RST_CLIP;
			state_reg.luma_layout <= vpcc_pkg::LAYOUT_RASTER;
			state_reg.z_run <= vpcc_pkg::RST_ENABLE;
			state_reg.o_run <= vpcc_pkg::RST_ENABLE;
			state_reg.raw_run <= vpcc_pkg::RST_ENABLE;
			state_reg.rdata <= vpcc_pkg::RST_RDATA;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign reg_rdata = state_reg.rdata;
	assign chan_zero_enable = state_reg.z_en;
	assign chan_zero_luma_chroma_shared = state_reg.z_shared;
	assign chan_zero_capture_kind = state_reg.z_kind;
	assign chan_one_enable = state_reg.o_en;
	assign chan_one_luma_chroma_shared = state_reg.o_shared;
	assign chan_one_capture_kind = state_reg.o_kind;
	assign chan_one_memory_layout_sel = state_reg.luma_layout;
	// Ancillary data has no layout choice; the port exists so the store path needs no special case.
	assign chan_one_anc_layout_sel = vpcc_pkg::LAYOUT_RASTER; // R3
	assign chan_one_field_flag = state_reg.o_field;
	assign chan_zero_run = state_reg.z_run;
	assign chan_one_run = state_reg.o_run;
	assign raw_capture_run = state_reg.raw_run;
	// Pure register level; the edge itself is chosen by logic outside the port.
	assign chan_two_edge_select = state_reg.t_edge; // R14
	assign blanking_clip_enable = state_reg.t_clip;

	////////////////////////////////////////////////////////////////////////////////
	// The checks use literal bit numbers on purpose, so a wrong package constant still trips them.
	a_layout_gated: assert property (@(posedge clk) disable iff (!rst_n) // R2
		chan_one_memory_layout_sel |-> (!chan_one_capture_kind[1]
		&& state_reg.o_layout))
		else $error("Sub-picture layout shown outside embedded-sync video.");

	a_layout_follows: assert property (@(posedge clk) disable iff (!rst_n) // R1
		(!chan_one_capture_kind[1] && state_reg.o_layout) |-> chan_one_memory_layout_sel)
		else $error("Layout select does not follow the stored bit.");

	a_anc_raster: assert property (@(posedge clk) disable iff (!rst_n) // R3
		chan_one_anc_layout_sel == vpcc_pkg::LAYOUT_RASTER)
		else $error("Ancillary data left raster order.");

	a_shared_write: assert property (@(posedge clk) disable iff (!rst_n) // R4
		(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_ONE)
		|=> chan_one_luma_chroma_shared == $past(reg_wdata[3]))
		else $error("Shared-stream bit not stored from the write.");

	a_joint_gate: assert property (@(posedge clk) disable iff (!rst_n) // R5
		(chan_zero_run || chan_one_run) && !chan_one_luma_chroma_shared
		|-> chan_zero_enable && chan_one_enable)
		else $error("Separate streams running without both enables.");

	a_joint_run: assert property (@(posedge clk) disable iff (!rst_n) // R5
		!chan_one_luma_chroma_shared && chan_zero_enable && chan_one_enable
		|-> chan_zero_run && chan_one_run)
		else $error("Separate streams idle with both enables set.");

	a_zero_write: assert property (@(posedge clk) disable iff (!rst_n) // R5
		(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_ZERO)
		|=> (chan_zero_enable == $past(reg_wdata[0]))
		&& (chan_zero_capture_kind == $past(reg_wdata[2:1])))
		else $error("Channel zero enable or kind not stored from the write.");

	a_force_shared: assert property (@(posedge clk) disable iff (!rst_n) // R6
		!chan_one_luma_chroma_shared |-> chan_zero_luma_chroma_shared)
		else $error("Channel zero shared bit not forced.");

	// A cleared bit written to channel zero only survives while channel one shares its stream.
	a_zero_forced: assert property (@(posedge clk) disable iff (!rst_n) // R6
		(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_ZERO)
		|=> chan_zero_luma_chroma_shared
		== ($past(reg_wdata[3]) || !chan_one_luma_chroma_shared))
		else $error("Channel zero shared bit neither stored nor forced.");

	a_solo_run: assert property (@(posedge clk) disable iff (!rst_n) // R7
		(chan_one_luma_chroma_shared && !chan_one_capture_kind[1])
		|-> (chan_one_run == chan_one_enable) && (chan_zero_run == chan_zero_enable))
		else $error("Shared-stream video channel not running on its own enable.");

	a_kind_write: assert property (@(posedge clk) disable iff (!rst_n) // R8
		(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_ONE)
		|=> chan_one_capture_kind == $past(reg_wdata[2:1]))
		else $error("Capture kind not stored from bits 2 to 1.");

	a_raw_idle: assert property (@(posedge clk) disable iff (!rst_n) // R9 R11
		chan_one_capture_kind[1] && !(chan_zero_enable && chan_one_enable)
		|-> !raw_capture_run && !chan_one_run && !chan_zero_run)
		else $error("Raw capture started with an enable clear.");

	a_raw_clear: assert property (@(posedge clk) disable iff (!rst_n) // R9
		!chan_one_capture_kind[1] |-> !raw_capture_run)
		else $error("Raw capture running in embedded-sync video.");

	a_raw_start: assert property (@(posedge clk) disable iff (!rst_n) // R11
		chan_one_capture_kind[1] && chan_zero_enable && chan_one_enable
		|-> raw_capture_run)
		else $error("Raw capture not running with both enables set.");

	a_enable_write: assert property (@(posedge clk) disable iff (!rst_n) // R12
		(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_ONE)
		|=> chan_one_enable == $past(reg_wdata[0]))
		else $error("Channel one enable not stored from bit 0.");

	a_one_hold: assert property (@(posedge clk) disable iff (!rst_n) // R12
		!(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_ONE)
		|=> $stable(chan_one_enable) && $stable(chan_one_capture_kind)
		&& $stable(chan_one_luma_chroma_shared))
		else $error("Channel one field changed without a write.");

	a_edge_write: assert property (@(posedge clk) disable iff (!rst_n) // R13 R14
		(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_TWO)
		|=> chan_two_edge_select == $past(reg_wdata[31]))
		else $error("Edge select not stored from bit 31.");

	a_two_hold: assert property (@(posedge clk) disable iff (!rst_n) // R14
		!(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_TWO)
		|=> $stable(chan_two_edge_select) && $stable(blanking_clip_enable))
		else $error("Channel two field changed without a write.");

	a_clip_write: assert property (@(posedge clk) disable iff (!rst_n) // R15
		(reg_write && reg_addr == vpcc_pkg::OFF_CHAN_TWO)
		|=> blanking_clip_enable == $past(reg_wdata[14]))
		else $error("Clip enable not stored from bit 14.");

	a_field_latch: assert property (@(posedge clk) disable iff (!rst_n) // R16
		(chan_one_enable && field_pulse) |=> chan_one_field_flag == $past(field_identity))
		else $error("Field flag missed an interrupt pulse.");

	a_field_hold: assert property (@(posedge clk) disable iff (!rst_n) // R16
		!(chan_one_enable && field_pulse) |=> $stable(chan_one_field_flag))
		else $error("Field flag changed without a pulse.");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // R17
		(reg_read && reg_addr == vpcc_pkg::OFF_CHAN_TWO)
		|=> (reg_rdata[30:15] == 16'h0000) && (reg_rdata[13:0] == 14'h0000))
		else $error("Reserved channel two bits read nonzero.");

	a_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		reg_write && reg_addr != vpcc_pkg::OFF_CHAN_ZERO
		&& reg_addr != vpcc_pkg::OFF_CHAN_ONE && reg_addr != vpcc_pkg::OFF_CHAN_TWO
		|=> $stable(chan_zero_enable) && $stable(chan_zero_capture_kind)
		&& $stable(chan_one_enable) && $stable(chan_two_edge_select))
		else $error("Write to an unmapped address changed a field.");

	// Every read answers with the register contents as they stood at the strobe edge.
	a_read_zero: assert property (@(posedge clk) disable iff (!rst_n) // R6
		(reg_read && reg_addr == vpcc_pkg::OFF_CHAN_ZERO)
		|=> reg_rdata == {28'h0, $past(chan_zero_luma_chroma_shared),
		$past(chan_zero_capture_kind), $past(chan_zero_enable)})
		else $error("Channel zero read back wrong.");

	a_read_one: assert property (@(posedge clk) disable iff (!rst_n) // R16
		(reg_read && reg_addr == vpcc_pkg::OFF_CHAN_ONE)
		|=> reg_rdata == {26'h0, $past(chan_one_field_flag), $past(state_reg.o_layout),
		$past(chan_one_luma_chroma_shared), $past(chan_one_capture_kind),
		$past(chan_one_enable)})
		else $error("Channel one read back wrong.");

	a_read_two: assert property (@(posedge clk) disable iff (!rst_n) // R13
		(reg_read && reg_addr == vpcc_pkg::OFF_CHAN_TWO)
		|=> (reg_rdata[31] == $past(chan_two_edge_select))
		&& (reg_rdata[14] == $past(blanking_clip_enable)))
		else $error("Channel two read back wrong.");

	a_read_status: assert property (@(posedge clk) disable iff (!rst_n) // R11
		(reg_read && reg_addr == vpcc_pkg::OFF_RUN_STATUS)
		|=> reg_rdata == {29'h0, $past(raw_capture_run), $past(chan_one_run),
		$past(chan_zero_run)})
		else $error("Run status read back wrong.");

	a_read_other: assert property (@(posedge clk) disable iff (!rst_n)
		reg_read && reg_addr != vpcc_pkg::OFF_CHAN_ZERO
		&& reg_addr != vpcc_pkg::OFF_CHAN_ONE && reg_addr != vpcc_pkg::OFF_CHAN_TWO
		&& reg_addr != vpcc_pkg::OFF_RUN_STATUS
		|=> reg_rdata == 32'h0000_0000)
		else $error("Unmapped read returned data.");

	a_read_window: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_read |=> reg_rdata == 32'h0000_0000)
		else $error("Read data present outside the read answer cycle.");

endmodule // vpcc_channel_control
`default_nettype wire

// file: tb/vpcc_testbench.sv
// Self-checking testbench of the video port channel control bank.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_write = 1'h0;
	logic reg_read = 1'h0;
	logic field_pulse = 1'h0;
	logic field_identity = 1'h0;
	logic [31:0] reg_rdata;
	logic z_en, z_sh, o_en, o_sh, o_lay, o_anc, o_fld, z_run, o_run, raw_run, edge_sel, clip_en;
	logic [1:0] z_kind, o_kind;
	logic m0_en, m0_sh, m1_en, m1_sh, m1_lay, m1_fld, m2_edge, m2_clip;
	logic [1:0] m0_kind, m1_kind;
	logic rd_seen = 1'h0;
	logic snap = 1'h0;
	logic [31:0] qr[$];
	logic [15:0] qo[$];
	int errors = 0;
	int num_checks = 0;
	wire logic [15:0] outs = {z_en, z_sh, z_kind, o_en, o_sh, o_kind, o_lay, o_anc, o_fld,
		raw_run, o_run, z_run, edge_sel, clip_en};

	vpcc_channel_control dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .field_pulse(field_pulse), .field_identity(field_identity),
		.chan_zero_enable(z_en), .chan_zero_luma_chroma_shared(z_sh),
		.chan_zero_capture_kind(z_kind), .chan_one_enable(o_en),
		.chan_one_luma_chroma_shared(o_sh), .chan_one_capture_kind(o_kind),
		.chan_one_memory_layout_sel(o_lay), .chan_one_anc_layout_sel(o_anc),
		.chan_one_field_flag(o_fld), .chan_zero_run(z_run), .chan_one_run(o_run),
		.raw_capture_run(raw_run), .chan_two_edge_select(edge_sel),
		.blanking_clip_enable(clip_en));

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Reference model, kept in step with every accepted write and field pulse.
	task automatic mreset();
		// Channel zero's shared bit leaves reset already forced by channel one's cleared bit.
		{m0_en, m0_sh, m0_kind, m1_en, m1_sh, m1_kind, m1_lay, m1_fld, m2_edge, m2_clip} = 12'h400;
	endtask

	// Order is raw, channel one, channel zero, matching the run status bits.
	function automatic logic [2:0] run_exp();
		logic joint;
		joint = m1_kind[1] | ~m1_sh;
		run_exp = {m1_kind[1] & m0_en & m1_en, joint ? m0_en & m1_en : m1_en,
			joint ? m0_en & m1_en : m0_en};
	endfunction

	function automatic logic [31:0] rd_exp(input logic [7:0] a);
		case (a)
			8'h00: rd_exp = {28'h0, m1_sh ? m0_sh : 1'h1, m0_kind, m0_en};
			8'h04: rd_exp = {26'h0, m1_fld, m1_lay, m1_sh, m1_kind, m1_en};
			8'h08: rd_exp = {m2_edge, 16'h0, m2_clip, 14'h0};
			8'h0C: rd_exp = {29'h0, run_exp()};
			default: rd_exp = 32'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus and pin drivers; each one notes what the monitor must see.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk);
		reg_write <= 1'h0;
		case (a)
			8'h00: {m0_sh, m0_kind, m0_en} = d[3:0];
			8'h04: {m1_lay, m1_sh, m1_kind, m1_en} = d[4:0];
			8'h08: {m2_edge, m2_clip} = {d[31], d[14]};
			default: ;
		endcase
		// The forced bit stays set once forced; only a later channel zero write clears it.
		if (!m1_sh) m0_sh = 1'h1;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		qr.push_back(rd_exp(a));
		@(posedge clk);
		reg_read <= 1'h0;
	endtask

	task automatic look();
		@(posedge clk);
		qo.push_back({m0_en, m1_sh ? m0_sh : 1'h1, m0_kind, m1_en, m1_sh, m1_kind,
			m1_lay & ~m1_kind[1], 1'h0, m1_fld, run_exp(), m2_edge, m2_clip});
		snap <= 1'h1;
		@(posedge clk);
		snap <= 1'h0;
	endtask

	// Pulses arriving while channel one is off must leave the flag alone.
	task automatic fp(input logic fi);
		@(posedge clk);
		field_pulse <= 1'h1;
		field_identity <= fi;
		if (m1_en) m1_fld = fi;
		@(posedge clk);
		field_pulse <= 1'h0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: read data stand only in the cycle after the strobe.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	always @(posedge clk) rd_seen <= reg_read;

	always @(negedge clk) begin
		if (rd_seen && qr.size() > 0) begin
			check("reg_rdata", reg_rdata, qr.pop_front());
		end
		if (snap && qo.size() > 0) begin
			check("outputs", {16'h0, outs}, {16'h0, qo.pop_front()});
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [31:0] e;
		mreset();
		d = $urandom(49491);
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		look();
		for (int i = 0; i < 4; i++) rd(8'(4 * i));
		repeat (60) begin
			d = $urandom();
			e = $urandom();
			wr(8'h04, d);
			if (d[2]) e[2:1] = d[2:1];
			wr(8'h00, e);
			wr(8'h08, $urandom());
			wr(8'h0C, $urandom());
			wr(8'($urandom_range(255, 16)), $urandom());
			fp(1'($urandom()));
			look();
			for (int i = 0; i < 5; i++) rd(8'(4 * i));
		end
		// A second reset in mid-run must bring every field back to its reset value.
		@(posedge clk);
		rst_n <= 1'h0;
		mreset();
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		look();
		rd(8'h04);
		// The last read answers after the task returns, so let the monitor see it first.
		repeat (2) @(posedge clk);
		if (qr.size() != 0 || qo.size() != 0) errors++;
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
